// ---- rtl/relay_scan_pkg.sv ----
// Constants, types and field layouts for the relay scan sequencer.
// Assumes a single 100 MHz clock domain.
// Summary of operation
// - All relays released after power-up
// - Sixteen drive bits, set means energized
// - Direct update applies pattern at once
// - Scanlist memory of 1024 ordered entries
// - Entry holds pattern, delay and advance criterion
// - Flag set when debounced and advanced
// - One-time stops at end, cyclic wraps
// - Trigger and strobe used in auto-scan only
// - Wait-for-trigger entry waits for active edge
// - Trigger edge selectable rising or falling
// - Debounce timer starts on pattern apply
// - Strobe issued when settle interval ends
// - Strobe waveform, polarity and width configurable
// - Front lines carry trigger, strobe, shutdown
// - First entry applied after first trigger
// - Settle is max of 8 ms and entry delay
// - Sequence runs until end or abort
`default_nettype none
package relay_scan_pkg;

    localparam int RELAY_COUNT = 16;
    localparam int LIST_DEPTH = 1024;
    localparam int INDEX_WIDTH = 10;
    localparam int DELAY_WIDTH = 16;
    localparam int TIMER_WIDTH = 24;
    localparam int WIDTH_WIDTH = 16;

    // Timing figures
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEBOUNCE_MS = 8;
    localparam int NS_PER_MS = 1000000;
    localparam int NS_PER_US = 1000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam logic [TIMER_WIDTH-1:0] US_CYCLES = TIMER_WIDTH'(NS_PER_US / CLK_PERIOD_NS);

    // Reset values and step sizes
    localparam logic [RELAY_COUNT-1:0] RELAYS_RELEASED = 16'h0000;
    localparam logic [INDEX_WIDTH-1:0] FIRST_INDEX = 10'h000;
    localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = 24'h000000;
    localparam logic [WIDTH_WIDTH-1:0] WIDTH_ZERO = 16'h0000;
    localparam logic [INDEX_WIDTH-1:0] INDEX_STEP = 10'h001;
    localparam logic [TIMER_WIDTH-1:0] TIMER_STEP = 24'h000001;
    localparam logic [WIDTH_WIDTH-1:0] WIDTH_STEP = 16'h0001;

    // Scanlist entry; delay counts microseconds from pattern apply, alongside debounce
    typedef struct packed {
        logic wait_trigger;
        logic strobe_enable;
        logic [DELAY_WIDTH-1:0] delay_us;
        logic [RELAY_COUNT-1:0] pattern;
    } entry_t;

    localparam int ENTRY_WIDTH = $bits(entry_t);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_DECIDE = 3'h2,
        ST_WAIT_TRIG = 3'h3,
        ST_APPLY = 3'h4,
        ST_SETTLE = 3'h5,
        ST_STROBE = 3'h6
    } scan_state_t;

endpackage
`default_nettype wire

// ---- rtl/scan_mem_if.sv ----
// Interface between the sequencer and its scanlist memory.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface scan_mem_if;
    logic wr_en;
    logic [relay_scan_pkg::INDEX_WIDTH-1:0] wr_addr;
    relay_scan_pkg::entry_t wr_data;
    logic [relay_scan_pkg::INDEX_WIDTH-1:0] rd_addr;
    relay_scan_pkg::entry_t rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- rtl/scan_memory.sv ----
// Scanlist storage with one write port and a registered read.
// Assumes read data is used one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module scan_memory (
    // Clock
    input wire logic clk,
    // Memory port
    scan_mem_if.mem port
);
    relay_scan_pkg::entry_t store [relay_scan_pkg::LIST_DEPTH];
    relay_scan_pkg::entry_t rd_reg;

    assign port.rd_data = rd_reg;

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
        rd_reg <= store[port.rd_addr];
    end
endmodule // scan_memory
`default_nettype wire

// ---- rtl/relay_scan_sequencer.sv ----
// Relay drive and auto-scan sequencer with instrument handshake.
// Assumes software control bits on the clk domain, front lines asynchronous.
`timescale 1ns/1ps
`default_nettype none
module relay_scan_sequencer #(
    parameter int DEBOUNCE_CYCLES = relay_scan_pkg::DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode and direct update
    input wire logic auto_scan_mode,
    input wire logic direct_update,
    input wire logic [15:0] direct_pattern,
    // Scan control
    input wire logic scan_start,
    input wire logic scan_abort,
    input wire logic scan_cyclic,
    input wire logic [9:0] scan_last_index,
    // Scanlist loading
    input wire logic list_write,
    input wire logic [9:0] list_addr,
    input wire logic [33:0] list_entry,
    // Handshake configuration
    input wire logic trigger_falling,
    input wire logic strobe_toggle,
    input wire logic strobe_active_low,
    input wire logic [15:0] strobe_width,
    // Status
    input wire logic advanced_clear,
    output logic advanced_flag,
    output logic scan_busy,
    output logic [9:0] scan_index,
    output logic shutdown_request,
    // Relay drive
    output logic [15:0] relay_drive,
    // Front panel lines
    input wire logic front_io_line_1,
    output logic front_io_line_0,
    output logic front_io_line_0_oe,
    input wire logic front_io_line_2_shutdown
);

    function automatic logic [relay_scan_pkg::TIMER_WIDTH-1:0] settle_target(
        input logic [relay_scan_pkg::DELAY_WIDTH-1:0] delay_us
    );
        logic [relay_scan_pkg::TIMER_WIDTH-1:0] user_cycles;
        logic [relay_scan_pkg::TIMER_WIDTH-1:0] fixed_cycles;
        user_cycles = relay_scan_pkg::TIMER_WIDTH'(delay_us * relay_scan_pkg::US_CYCLES);
        fixed_cycles = relay_scan_pkg::TIMER_WIDTH'(DEBOUNCE_CYCLES);
        settle_target = (user_cycles > fixed_cycles) ? user_cycles : fixed_cycles;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and front line synchronisers

    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    logic trig_meta_reg, trig_sync_reg, trig_prev_reg;
    logic shdn_meta_reg, shdn_sync_reg;
    logic trig_edge;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
            shdn_meta_reg <= 1'b1;
            shdn_sync_reg <= 1'b1;
        end else begin
            trig_meta_reg <= front_io_line_1;
            trig_sync_reg <= trig_meta_reg;
            trig_prev_reg <= trig_sync_reg;
            shdn_meta_reg <= front_io_line_2_shutdown;
            shdn_sync_reg <= shdn_meta_reg;
        end
    end

    // Active edge selected by configuration
    assign trig_edge = trigger_falling ? (trig_prev_reg & ~trig_sync_reg)
                                       : (~trig_prev_reg & trig_sync_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Scanlist memory

    scan_mem_if mem_bus ();
    scan_memory u_memory (
        .clk(clk),
        .port(mem_bus.mem)
    );

    relay_scan_pkg::scan_state_t state_reg, state_next;
    logic [9:0] index_reg, index_next;
    relay_scan_pkg::entry_t entry_reg, entry_next;
    logic first_reg, first_next;

    assign mem_bus.wr_en = list_write;
    assign mem_bus.wr_addr = list_addr;
    assign mem_bus.wr_data = relay_scan_pkg::entry_t'(list_entry);
    assign mem_bus.rd_addr = index_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic [relay_scan_pkg::TIMER_WIDTH-1:0] timer_reg, timer_next, target_reg, target_next;
    logic [15:0] width_reg, width_next;
    logic [15:0] relays_reg, relays_next;
    logic strobe_level_reg, strobe_level_next;
    logic flag_reg, flag_next;
    logic advance;
    logic settle_done;

    assign settle_done = (timer_reg + relay_scan_pkg::TIMER_STEP) >= target_reg;

    always_comb begin
        state_next = state_reg;
        index_next = index_reg;
        entry_next = entry_reg;
        first_next = first_reg;
        timer_next = timer_reg;
        target_next = target_reg;
        width_next = width_reg;
        relays_next = relays_reg;
        strobe_level_next = strobe_level_reg;
        advance = 1'b0;
        if (!auto_scan_mode) begin
            state_next = relay_scan_pkg::ST_IDLE;
            if (direct_update) begin
                relays_next = direct_pattern;
            end
            if (!strobe_toggle) begin
                strobe_level_next = 1'b0;
            end
        end else if (scan_abort) begin
            state_next = relay_scan_pkg::ST_IDLE;
            if (!strobe_toggle) begin
                strobe_level_next = 1'b0;
            end
        end else begin
            case (state_reg)
                relay_scan_pkg::ST_IDLE: begin
                    if (scan_start) begin
                        index_next = relay_scan_pkg::FIRST_INDEX;
                        first_next = 1'b1;
                        state_next = relay_scan_pkg::ST_FETCH;
                    end
                end
                relay_scan_pkg::ST_FETCH: begin
                    state_next = relay_scan_pkg::ST_DECIDE;
                end
                relay_scan_pkg::ST_DECIDE: begin
                    entry_next = mem_bus.rd_data;
                    if (mem_bus.rd_data.wait_trigger || first_reg) begin
                        state_next = relay_scan_pkg::ST_WAIT_TRIG;
                    end else begin
                        state_next = relay_scan_pkg::ST_APPLY;
                    end
                end
                relay_scan_pkg::ST_WAIT_TRIG: begin
                    if (trig_edge) begin
                        state_next = relay_scan_pkg::ST_APPLY;
                    end
                end
                relay_scan_pkg::ST_APPLY: begin
                    relays_next = entry_reg.pattern;
                    first_next = 1'b0;
                    timer_next = relay_scan_pkg::TIMER_ZERO;
                    target_next = settle_target(entry_reg.delay_us);
                    state_next = relay_scan_pkg::ST_SETTLE;
                end
                relay_scan_pkg::ST_SETTLE: begin
                    timer_next = timer_reg + relay_scan_pkg::TIMER_STEP;
                    if (settle_done) begin
                        state_next = relay_scan_pkg::ST_STROBE;
                        width_next = relay_scan_pkg::WIDTH_ZERO;
                        if (entry_reg.strobe_enable) begin
                            strobe_level_next = strobe_toggle ? ~strobe_level_reg : 1'b1;
                        end
                    end
                end
                relay_scan_pkg::ST_STROBE: begin
                    width_next = width_reg + relay_scan_pkg::WIDTH_STEP;
                    if (strobe_toggle || !entry_reg.strobe_enable ||
                        (width_next >= strobe_width)) begin
                        if (!strobe_toggle) begin
                            strobe_level_next = 1'b0;
                        end
                        advance = 1'b1;
                        if (index_reg == scan_last_index) begin
                            if (scan_cyclic) begin
                                index_next = relay_scan_pkg::FIRST_INDEX;
                                state_next = relay_scan_pkg::ST_FETCH;
                            end else begin
                                state_next = relay_scan_pkg::ST_IDLE;
                            end
                        end else begin
                            index_next = index_reg + relay_scan_pkg::INDEX_STEP;
                            state_next = relay_scan_pkg::ST_FETCH;
                        end
                    end
                end
                default: begin
                    state_next = relay_scan_pkg::ST_IDLE;
                end
            endcase
        end
        // Hardware set wins over software clear
        flag_next = advance | (flag_reg & ~advanced_clear);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= relay_scan_pkg::ST_IDLE;
            index_reg <= relay_scan_pkg::FIRST_INDEX;
            entry_reg <= '0;
            first_reg <= 1'b0;
            timer_reg <= relay_scan_pkg::TIMER_ZERO;
            target_reg <= relay_scan_pkg::TIMER_ZERO;
            width_reg <= relay_scan_pkg::WIDTH_ZERO;
            relays_reg <= relay_scan_pkg::RELAYS_RELEASED;
            strobe_level_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            index_reg <= index_next;
            entry_reg <= entry_next;
            first_reg <= first_next;
            timer_reg <= timer_next;
            target_reg <= target_next;
            width_reg <= width_next;
            relays_reg <= relays_next;
            strobe_level_reg <= strobe_level_next;
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    logic strobe_pin_reg, strobe_pin_next, oe_reg, oe_next, busy_reg, busy_next, shdn_reg;
    always_comb begin
        strobe_pin_next = strobe_level_next ^ strobe_active_low;
        oe_next = auto_scan_mode;
        busy_next = (state_next != relay_scan_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_pin_reg <= 1'b0;
            oe_reg <= 1'b0;
            busy_reg <= 1'b0;
            shdn_reg <= 1'b0;
        end else begin
            strobe_pin_reg <= strobe_pin_next;
            oe_reg <= oe_next;
            busy_reg <= busy_next;
            shdn_reg <= ~shdn_sync_reg;
        end
    end

    assign relay_drive = relays_reg;
    assign front_io_line_0 = strobe_pin_reg;
    assign front_io_line_0_oe = oe_reg;
    assign scan_busy = busy_reg;
    assign scan_index = index_reg;
    assign advanced_flag = flag_reg;
    assign shutdown_request = shdn_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_reset_released;
        @(posedge clk) $rose(rst_n) |-> relay_drive == relay_scan_pkg::RELAYS_RELEASED;
    endproperty
    a_reset_released: assert property (p_reset_released) else $error("relays not released");

    property p_direct_update;
        @(posedge clk) disable iff (!rst_n)
        (!auto_scan_mode && direct_update) |=> relay_drive == $past(direct_pattern);
    endproperty
    a_direct_update: assert property (p_direct_update) else $error("direct update late");

    property p_wait_holds;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == relay_scan_pkg::ST_WAIT_TRIG && auto_scan_mode && !scan_abort && !trig_edge)
        |=> state_reg == relay_scan_pkg::ST_WAIT_TRIG && $stable(relays_reg);
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("moved without trigger");

    property p_timer_start;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == relay_scan_pkg::ST_APPLY && auto_scan_mode && !scan_abort)
        |=> state_reg == relay_scan_pkg::ST_SETTLE && timer_reg == relay_scan_pkg::TIMER_ZERO
            && relays_reg == entry_reg.pattern;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer not started");

    property p_settle_min;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == relay_scan_pkg::ST_STROBE && $past(state_reg) == relay_scan_pkg::ST_SETTLE)
        |-> $past(timer_reg) + relay_scan_pkg::TIMER_STEP >= DEBOUNCE_CYCLES;
    endproperty
    a_settle_min: assert property (p_settle_min) else $error("settle too short");

    property p_strobe_after_settle;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == relay_scan_pkg::ST_SETTLE && settle_done && auto_scan_mode && !scan_abort)
        |=> state_reg == relay_scan_pkg::ST_STROBE && (!entry_reg.strobe_enable
            || (front_io_line_0 ^ strobe_active_low)
            == (strobe_toggle ? !$past(strobe_level_reg) : 1'b1));
    endproperty
    a_strobe_after_settle: assert property (p_strobe_after_settle) else $error("no strobe");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n) advance |=> advanced_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        (auto_scan_mode && scan_abort) |=> state_reg == relay_scan_pkg::ST_IDLE
            && $stable(relays_reg) && (strobe_toggle || !strobe_level_reg);
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");

    property p_one_time_end;
        @(posedge clk) disable iff (!rst_n)
        (advance && !scan_cyclic && index_reg == scan_last_index && !scan_abort)
        |=> state_reg == relay_scan_pkg::ST_IDLE ##1 !scan_busy;
    endproperty
    a_one_time_end: assert property (p_one_time_end) else $error("one-time did not stop");

    property p_strobe_only_auto;
        @(posedge clk) disable iff (!rst_n) !auto_scan_mode [*2] |-> !front_io_line_0_oe;
    endproperty
    a_strobe_only_auto: assert property (p_strobe_only_auto) else $error("strobe driven");

endmodule // relay_scan_sequencer
`default_nettype wire

// ---- verification/instrument_model.sv ----
// Behavioural measurement instrument on the handshake lines.
// Assumes the strobe pin is registered on clk and the trigger is synchronised.
`timescale 1ns/1ps
`default_nettype none
module instrument_model (
    // Clock
    input wire logic clk,
    // Handshake configuration
    input wire logic strobe_toggle,
    input wire logic strobe_active_low,
    input wire logic trigger_falling,
    input wire logic armed,
    input wire logic kick,
    input wire logic [7:0] resp_cycles,
    // Lines
    input wire logic strobe_pin,
    output logic trig,
    output int meas_count
);
    logic prev;
    logic ev;
    initial begin
        trig = 1'b0;
        meas_count = 0;
        prev = 1'b0;
        forever begin
            @(posedge clk);
            ev = strobe_toggle ? (strobe_pin !== prev)
                : ((strobe_pin ^ strobe_active_low) === 1'b1 && (prev ^ strobe_active_low) === 1'b0);
            prev = strobe_pin;
            if (ev)
                meas_count++;
            if ((ev && armed) || kick) begin
                repeat (resp_cycles) @(posedge clk);
                #1 trig = ~trigger_falling;
                repeat (4) @(posedge clk);
                #1 trig = trigger_falling;
                prev = strobe_pin;
            end else begin
                #1 trig = trigger_falling;
            end
        end
    end
endmodule // instrument_model
`default_nettype wire

// ---- verification/relay_scan_sequencer_tb.sv ----
// Self-checking bench for the relay scan sequencer.
// Assumes a shortened debounce count and the instrument model.
`timescale 1ns/1ps
`default_nettype none
module relay_scan_sequencer_tb;
    localparam int DEB = 50;
    localparam int LIMIT = 20000;
    logic clk, reset_n, auto_scan_mode, direct_update, scan_start, scan_abort, scan_cyclic;
    logic [15:0] direct_pattern, strobe_width, relay_drive;
    logic [9:0] scan_last_index, list_addr, scan_index;
    logic list_write, trigger_falling, strobe_toggle, strobe_active_low, advanced_clear;
    logic [33:0] list_entry;
    logic advanced_flag, scan_busy, shutdown_request, front_io_line_0, front_io_line_0_oe;
    logic front_io_line_1, front_io_line_2_shutdown, armed, kick;
    int meas_count, err_count, tests_run, cycles;

    relay_scan_sequencer #(.DEBOUNCE_CYCLES(DEB)) i_dut (
        .clk(clk), .reset_n(reset_n), .auto_scan_mode(auto_scan_mode),
        .direct_update(direct_update), .direct_pattern(direct_pattern),
        .scan_start(scan_start), .scan_abort(scan_abort), .scan_cyclic(scan_cyclic),
        .scan_last_index(scan_last_index), .list_write(list_write), .list_addr(list_addr),
        .list_entry(list_entry), .trigger_falling(trigger_falling),
        .strobe_toggle(strobe_toggle), .strobe_active_low(strobe_active_low),
        .strobe_width(strobe_width), .advanced_clear(advanced_clear),
        .advanced_flag(advanced_flag), .scan_busy(scan_busy), .scan_index(scan_index),
        .shutdown_request(shutdown_request), .relay_drive(relay_drive),
        .front_io_line_1(front_io_line_1), .front_io_line_0(front_io_line_0),
        .front_io_line_0_oe(front_io_line_0_oe),
        .front_io_line_2_shutdown(front_io_line_2_shutdown)
    );

    instrument_model i_inst (
        .clk(clk), .strobe_toggle(strobe_toggle), .strobe_active_low(strobe_active_low),
        .trigger_falling(trigger_falling), .armed(armed), .kick(kick),
        .resp_cycles(8'h05), .strobe_pin(front_io_line_0), .trig(front_io_line_1),
        .meas_count(meas_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic load(input logic [9:0] a, input logic w, input logic [15:0] d,
                        input logic [15:0] p);
        list_addr = a;
        list_entry = {w, 1'b1, d, p};
        list_write = 1'b1;
        tick();
        list_write = 1'b0;
        tick();
    endtask

    task automatic pulse_kick();
        kick = 1'b1;
        tick();
        kick = 1'b0;
    endtask

    function automatic logic strobe_ev(input logic prev);
        return strobe_toggle ? (front_io_line_0 !== prev)
            : ((front_io_line_0 ^ strobe_active_low) === 1'b1);
    endfunction

    // Waits for a pattern, then times the settle interval and, when strobe_toggle is low, the pulse width
    task automatic wait_apply(input logic [15:0] p, input int n);
        int c;
        int w;
        logic prev;
        c = 0;
        while (relay_drive !== p && c < 2000) begin
            tick();
            c++;
        end
        chk(relay_drive, p, "applied pattern");
        c = 0;
        do begin
            prev = front_io_line_0;
            tick();
            c++;
        end while (!strobe_ev(prev) && c < 2000);
        chk(c >= n && c <= n + 4, 1, "settle interval");
        if (!strobe_toggle) begin
            w = 0;
            while ((front_io_line_0 ^ strobe_active_low) === 1'b1 && w < 100) begin
                tick();
                w++;
            end
            chk(w, strobe_width, "strobe width");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int c;
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        reset_n = 1'b0;
        {auto_scan_mode, direct_update, scan_start, scan_abort, scan_cyclic} = 5'h00;
        {list_write, trigger_falling, strobe_toggle, strobe_active_low} = 4'h0;
        {advanced_clear, armed, kick} = 3'h0;
        front_io_line_2_shutdown = 1'b1;
        direct_pattern = 16'h0000;
        strobe_width = 16'h0003;
        scan_last_index = 10'h002;
        list_addr = 10'h000;
        list_entry = 34'h000000000;
        tick(20);
        chk(relay_drive, 16'h0000, "relays after reset");
        reset_n = 1'b1;
        tick(5);
        chk(relay_drive, 16'h0000, "relays released");
        chk(front_io_line_0_oe, 1'b0, "strobe pin idle in direct mode");

        // Direct update, back to back
        direct_update = 1'b1;
        direct_pattern = 16'h8001;
        tick();
        direct_pattern = 16'h7FFE;
        tick();
        direct_update = 1'b0;
        tick();
        chk(relay_drive, 16'h7FFE, "direct pattern");
        tick(DEB);
        $display("test direct done");

        // One-time scan: trigger gated entry, free entry, long delay entry
        load(10'h000, 1'b1, 16'h0000, 16'hA5A5);
        load(10'h001, 1'b0, 16'h0000, 16'h5A5A);
        load(10'h002, 1'b1, 16'h0001, 16'hFFFF);
        auto_scan_mode = 1'b1;
        scan_start = 1'b1;
        tick();
        scan_start = 1'b0;
        tick(30);
        chk(relay_drive, 16'h7FFE, "held before first trigger");
        chk(scan_busy, 1'b1, "busy while scanning");
        chk(front_io_line_0_oe, 1'b1, "strobe pin driven");
        pulse_kick();
        wait_apply(16'hA5A5, DEB);
        wait_apply(16'h5A5A, DEB);
        tick(40);
        chk(relay_drive, 16'h5A5A, "held until trigger edge");
        pulse_kick();
        wait_apply(16'hFFFF, 100);
        c = 0;
        while (scan_busy !== 1'b0 && c < 50) begin
            tick();
            c++;
        end
        chk(scan_busy, 1'b0, "one-time scan stops");
        chk(relay_drive, 16'hFFFF, "last pattern kept");
        chk(scan_index, 10'h002, "index stops at last entry");
        chk(advanced_flag, 1'b1, "advanced flag set");
        advanced_clear = 1'b1;
        tick();
        advanced_clear = 1'b0;
        tick();
        chk(advanced_flag, 1'b0, "advanced flag cleared");
        $display("test one_time done");

        // Cyclic scan, falling trigger, active-low toggle strobe, then abort
        load(10'h001, 1'b1, 16'h0000, 16'h5A5A);
        scan_last_index = 10'h001;
        scan_cyclic = 1'b1;
        trigger_falling = 1'b1;
        strobe_toggle = 1'b1;
        strobe_active_low = 1'b1;
        tick(10);
        armed = 1'b1;
        scan_start = 1'b1;
        tick();
        scan_start = 1'b0;
        tick(5);
        pulse_kick();
        c = meas_count;
        while (meas_count < c + 3 && cycles < LIMIT - 100)
            tick();
        chk(relay_drive, 16'hA5A5, "wrapped to first entry");
        scan_abort = 1'b1;
        tick();
        scan_abort = 1'b0;
        tick(60);
        chk(scan_busy, 1'b0, "abort returns idle");
        chk(relay_drive, 16'hA5A5, "abort keeps pattern");
        armed = 1'b0;
        direct_update = 1'b1;
        direct_pattern = 16'h0F0F;
        tick();
        direct_update = 1'b0;
        tick(2);
        chk(relay_drive, 16'hA5A5, "direct refused in auto");
        $display("test cyclic_abort done");

        // Shutdown line report
        front_io_line_2_shutdown = 1'b0;
        tick(5);
        chk(shutdown_request, 1'b1, "shutdown reported");
        front_io_line_2_shutdown = 1'b1;
        tick(5);
        chk(shutdown_request, 1'b0, "shutdown released");
        $display("test shutdown done");
        close_out();
    end
endmodule // relay_scan_sequencer_tb
`default_nettype wire
